// ==== rtl/charge_mode_pin_decoder.sv ====
// Charging-port mode decoder with load detection, APB registers and interrupt.
//
// Chosen here: register access over APB and the address map.
`default_nettype none
module charge_mode_pin_decoder #(
    parameter logic [31:0] ASSERT_CYCLES     = charge_mode_pkg::ASSERT_CYCLES,
    parameter logic [31:0] RELEASE_CYCLES    = charge_mode_pkg::RELEASE_CYCLES,
    parameter logic [31:0] PW_IDLE_CYCLES    = charge_mode_pkg::PW_IDLE_CYCLES,
    parameter logic [31:0] PW_DISCH_CYCLES   = charge_mode_pkg::PW_DISCH_CYCLES,
    parameter logic [31:0] MODE_DISCH_CYCLES = charge_mode_pkg::MODE_DISCH_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Mode select pins
    input  wire logic        mode_select_a,
    input  wire logic        mode_select_b,
    input  wire logic        mode_select_c,
    input  wire logic        limit_select,
    // Load comparators and port monitors
    input  wire logic        load_above_upper,
    input  wire logic        load_below_lower,
    input  wire logic        load_below_wake_floor,
    input  wire logic        load_above_wake_ceiling,
    input  wire logic        primary_detect,
    input  wire logic        hid_present,
    // Port control
    output logic             port_discharge,
    output logic             data_connect,
    output logic             limit_high_sel,
    output logic             limit_wake_sel,
    output logic             load_present_n,
    output logic             irq
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    charge_mode_pkg::pins_s pins_raw;
    logic [charge_mode_pkg::PINS_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
    charge_mode_pkg::pins_s pin;

    assign pins_raw = '{mode_select_a, mode_select_b, mode_select_c, limit_select, load_above_upper,
                        load_below_lower, load_below_wake_floor, load_above_wake_ceiling,
                        primary_detect, hid_present};
    assign pin = charge_mode_pkg::pins_s'(filt_reg);

    // A bit moves only once the second and third stages agree.
    always_comb begin
        filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;
        end else begin
            s1_reg   <= pins_raw;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    // ****************************************************************
    // Mode decode and mode change
    // ****************************************************************
    function automatic charge_mode_pkg::mode_cfg_s decode(input logic [3:0] sel);
        charge_mode_pkg::mode_cfg_s c;
        c = charge_mode_pkg::CFG_RESET;
        unique casez (sel)
            4'b000?: c = charge_mode_pkg::CFG_RESET;
            4'b0010, 4'b0110: c = '{charge_mode_pkg::dedicated_auto_mode, 1'b1, 1'b0, charge_mode_pkg::det_none};
            4'b0011: c = '{charge_mode_pkg::dedicated_auto_mode, 1'b1, 1'b0, charge_mode_pkg::det_power_wake};
            4'b0111: c = '{charge_mode_pkg::dedicated_auto_mode, 1'b1, 1'b0, charge_mode_pkg::det_ordinary};
            4'b?10?: c = '{charge_mode_pkg::standard_port_first, sel[0], 1'b1, charge_mode_pkg::det_none};
            4'b100?: c = '{charge_mode_pkg::dedicated_shorted_mode, sel[0], 1'b0, charge_mode_pkg::det_none};
            4'b101?: c = '{charge_mode_pkg::divider_one_amp_mode, sel[0], 1'b0, charge_mode_pkg::det_none};
            4'b1110: c = '{charge_mode_pkg::standard_port_second, 1'b0, 1'b1, charge_mode_pkg::det_none};
            4'b1111: c = '{charge_mode_pkg::charging_downstream, 1'b1, 1'b1, charge_mode_pkg::det_downstream};
        endcase
        return c;
    endfunction

    logic [3:0]                 sel;
    charge_mode_pkg::mode_cfg_s target;
    charge_mode_pkg::mode_cfg_s applied_reg, applied_next;
    logic [3:0]                 applied_sel_reg, applied_sel_next;
    logic                       busy_reg, busy_next;
    logic [31:0]                mcnt_reg, mcnt_next;
    logic                       hold, swap, ev_mode, ev_done;
    logic [31:0]                ctrl_reg;

    assign sel    = {pin.mode_select_a, pin.mode_select_b, pin.mode_select_c, pin.limit_select};
    assign target = decode(sel);

    always_comb begin
        applied_next     = applied_reg;
        applied_sel_next = applied_sel_reg;
        busy_next        = busy_reg;
        mcnt_next        = mcnt_reg;
        ev_mode          = 1'b0;
        ev_done          = 1'b0;
        // A detected HID keeps a data-connected mode so the wake path is not cut.
        hold = ctrl_reg[charge_mode_pkg::CTRL_HID_HOLD_BIT] & pin.hid_present & applied_reg.data_on;
        swap = (applied_sel_reg[3:1] == 3'b111) && (sel[3:1] == 3'b111);
        if (busy_reg) begin
            mcnt_next = mcnt_reg + 32'h0000_0001;
            if (mcnt_reg >= MODE_DISCH_CYCLES - 32'h0000_0001) begin
                busy_next        = 1'b0;
                mcnt_next        = '0;
                applied_next     = target;
                applied_sel_next = sel;
                ev_done          = 1'b1;
            end
        end else if (sel != applied_sel_reg && !hold) begin
            ev_mode = 1'b1;
            if (swap) begin
                applied_next     = target;
                applied_sel_next = sel;
            end else begin
                busy_next = 1'b1;
                mcnt_next = '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            applied_reg     <= charge_mode_pkg::CFG_RESET;
            applied_sel_reg <= 4'h0;
            busy_reg        <= 1'b0;
            mcnt_reg        <= '0;
        end else begin
            applied_reg     <= applied_next;
            applied_sel_reg <= applied_sel_next;
            busy_reg        <= busy_next;
            mcnt_reg        <= mcnt_next;
        end
    end

    // ****************************************************************
    // Load detection and port outputs
    // ****************************************************************
    charge_mode_pkg::pw_e pw_reg, pw_next;
    logic        present_reg, present_next;
    logic [31:0] lcnt_reg, lcnt_next;
    logic        pd_next, dc_next, lh_next, lw_next;

    always_comb begin
        pw_next      = pw_reg;
        present_next = present_reg;
        lcnt_next    = '0;
        if (busy_next || applied_sel_next != applied_sel_reg ||
            applied_reg.detect == charge_mode_pkg::det_none) begin
            pw_next      = charge_mode_pkg::pw_active;
            present_next = 1'b0;
        end else if (applied_reg.detect == charge_mode_pkg::det_power_wake) begin
            unique case (pw_reg)
                charge_mode_pkg::pw_active: begin
                    if (pin.below_wake_floor) begin
                        lcnt_next = lcnt_reg + 32'h0000_0001;
                        if (lcnt_reg >= PW_IDLE_CYCLES - 32'h0000_0001) begin
                            pw_next   = charge_mode_pkg::pw_idle;
                            lcnt_next = '0;
                        end
                    end
                end
                charge_mode_pkg::pw_idle: begin
                    if (pin.above_wake_ceiling) begin
                        pw_next = charge_mode_pkg::pw_discharge;
                    end
                end
                charge_mode_pkg::pw_discharge: begin
                    lcnt_next = lcnt_reg + 32'h0000_0001;
                    if (lcnt_reg >= PW_DISCH_CYCLES - 32'h0000_0001) begin
                        pw_next   = charge_mode_pkg::pw_active;
                        lcnt_next = '0;
                    end
                end
                default: pw_next = charge_mode_pkg::pw_active;
            endcase
            present_next = (pw_next != charge_mode_pkg::pw_idle);
        end else if (applied_reg.detect == charge_mode_pkg::det_downstream && pin.primary_detect) begin
            present_next = 1'b1;
        end else if (!present_reg) begin
            if (pin.above_upper) begin
                lcnt_next = lcnt_reg + 32'h0000_0001;
                if (lcnt_reg >= ASSERT_CYCLES - 32'h0000_0001) begin
                    present_next = 1'b1;
                    lcnt_next    = '0;
                end
            end
        end else if (pin.below_lower) begin
            lcnt_next = lcnt_reg + 32'h0000_0001;
            if (lcnt_reg >= RELEASE_CYCLES - 32'h0000_0001) begin
                present_next = 1'b0;
                lcnt_next    = '0;
            end
        end
        // Power-wake limit and discharge only apply while pattern 0011 is in force.
        pd_next = busy_next || applied_next.mode == charge_mode_pkg::mode_discharge ||
                  (applied_next.detect == charge_mode_pkg::det_power_wake &&
                   pw_next == charge_mode_pkg::pw_discharge);
        dc_next = applied_next.data_on && !busy_next;
        lw_next = applied_next.detect == charge_mode_pkg::det_power_wake &&
                  pw_next == charge_mode_pkg::pw_idle && !busy_next;
        lh_next = applied_next.limit_high && !lw_next;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_reg         <= charge_mode_pkg::pw_active;
            present_reg    <= 1'b0;
            lcnt_reg       <= '0;
            port_discharge <= 1'b1;
            data_connect   <= 1'b0;
            limit_high_sel <= 1'b0;
            limit_wake_sel <= 1'b0;
            load_present_n <= 1'b1;
        end else begin
            pw_reg         <= pw_next;
            present_reg    <= present_next;
            lcnt_reg       <= lcnt_next;
            port_discharge <= pd_next;
            data_connect   <= dc_next;
            limit_high_sel <= lh_next;
            limit_wake_sel <= lw_next;
            load_present_n <= !present_next;
        end
    end

    // ****************************************************************
    // APB registers and interrupt
    // ****************************************************************
    logic [31:0]                        ctrl_next, prdata_next;
    logic [charge_mode_pkg::IRQ_W-1:0]  istat_reg, istat_next, mask_reg, mask_next, ev, w1c;
    logic                               pready_next, pslverr_next, irq_next, wr;

    always_comb begin
        ctrl_next    = ctrl_reg;
        mask_next    = mask_reg;
        prdata_next  = prdata;
        pslverr_next = pslverr;
        w1c          = '0;
        pready_next  = psel && penable && !pready;
        wr           = psel && penable && pready && pwrite;
        ev = '0;
        ev[charge_mode_pkg::EV_MODE_BIT] = ev_mode;
        ev[charge_mode_pkg::EV_LOAD_BIT] = present_next && !present_reg;
        ev[charge_mode_pkg::EV_FREE_BIT] = !present_next && present_reg;
        ev[charge_mode_pkg::EV_DONE_BIT] = ev_done;
        if (pready_next) begin
            prdata_next  = '0;
            pslverr_next = 1'b0;
            unique case (paddr)
                charge_mode_pkg::CTRL_OFS:       prdata_next = ctrl_reg;
                charge_mode_pkg::STATE_OFS: begin
                    prdata_next[charge_mode_pkg::ST_MODE_LSB +: 3] = applied_reg.mode;
                    prdata_next[charge_mode_pkg::ST_BUSY_BIT]      = busy_reg;
                    prdata_next[charge_mode_pkg::ST_LOAD_BIT]      = present_reg;
                    prdata_next[charge_mode_pkg::ST_PW_LSB +: 2]   = pw_reg;
                    prdata_next[charge_mode_pkg::ST_PINS_LSB +: charge_mode_pkg::PINS_W] = filt_reg;
                end
                charge_mode_pkg::IRQ_STATUS_OFS: prdata_next[charge_mode_pkg::IRQ_W-1:0] = istat_reg;
                charge_mode_pkg::IRQ_MASK_OFS:   prdata_next[charge_mode_pkg::IRQ_W-1:0] = mask_reg;
                default:                         pslverr_next = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                charge_mode_pkg::CTRL_OFS:       ctrl_next = {31'h0, pwdata[charge_mode_pkg::CTRL_HID_HOLD_BIT]};
                charge_mode_pkg::IRQ_STATUS_OFS: w1c = pwdata[charge_mode_pkg::IRQ_W-1:0];
                charge_mode_pkg::IRQ_MASK_OFS:   mask_next = pwdata[charge_mode_pkg::IRQ_W-1:0];
                default:                         ctrl_next = ctrl_reg;
            endcase
        end
        // A new event wins over a clear in the same cycle.
        istat_next = (istat_reg & ~w1c) | ev;
        irq_next   = |(istat_next & mask_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= charge_mode_pkg::CTRL_RESET;
            mask_reg  <= charge_mode_pkg::IRQ_RESET;
            istat_reg <= charge_mode_pkg::IRQ_RESET;
            prdata    <= '0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            irq       <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            mask_reg  <= mask_next;
            istat_reg <= istat_next;
            prdata    <= prdata_next;
            pready    <= pready_next;
            pslverr   <= pslverr_next;
            irq       <= irq_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_follow_pins: assert property (@(posedge pclk) disable iff (!presetn)
        (!busy_reg && sel != applied_sel_reg && !hold) |=> (busy_reg || applied_sel_reg == $past(sel)))
        else $error("Mode did not follow the select pins.");
    a_dedicated_data_off: assert property (@(posedge pclk) disable iff (!presetn)
        (applied_reg.mode == charge_mode_pkg::dedicated_auto_mode) |-> !data_connect)
        else $error("Data lines connected in dedicated mode.");
    a_wake_limit_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (pw_reg == charge_mode_pkg::pw_idle && applied_reg.detect == charge_mode_pkg::det_power_wake &&
         !busy_reg) |-> (limit_wake_sel && !limit_high_sel && load_present_n))
        else $error("Idle power wake without wake limit.");
    a_wake_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (pw_reg == charge_mode_pkg::pw_idle && pin.above_wake_ceiling && !busy_next &&
         applied_reg.detect == charge_mode_pkg::det_power_wake && applied_sel_next == applied_sel_reg)
        |=> (port_discharge && !load_present_n)[*2])
        else $error("Wake load did not start a discharge.");
    a_swap_no_discharge: assert property (@(posedge pclk) disable iff (!presetn)
        (!busy_reg && swap && sel != applied_sel_reg && !hold) |=> (!port_discharge && !busy_reg))
        else $error("Discharge on a 1111/1110 change.");
    a_primary_present: assert property (@(posedge pclk) disable iff (!presetn)
        (applied_reg.detect == charge_mode_pkg::det_downstream && pin.primary_detect && !busy_next &&
         applied_sel_next == applied_sel_reg) |=> !load_present_n)
        else $error("Primary detection not reported.");
    a_discharge_pattern: assert property (@(posedge pclk) disable iff (!presetn)
        (applied_reg.mode == charge_mode_pkg::mode_discharge) |-> (port_discharge && !data_connect && load_present_n))
        else $error("Discharge pattern not honoured.");
    a_quiet_status: assert property (@(posedge pclk) disable iff (!presetn)
        (applied_reg.detect == charge_mode_pkg::det_none || busy_reg) |=> load_present_n)
        else $error("Load reported in a mode without detection.");
    a_assert_delay: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(load_present_n) && applied_reg.detect == charge_mode_pkg::det_ordinary) |->
        $past(lcnt_reg) >= ASSERT_CYCLES - 32'h0000_0001)
        else $error("Load reported before the assert time.");
endmodule
`default_nettype wire

// ==== inc/charge_mode_pkg.sv ====
// Shared constants and types of the charging-port mode pin decoder.
`default_nettype none
package charge_mode_pkg;
    // Clock rate and times.
    localparam longint CLK_KHZ          = 250_000;
    localparam longint ASSERT_MS        = 200;
    localparam longint RELEASE_MS       = 3000;
    localparam longint PW_IDLE_MS       = 15000;
    localparam longint PW_DISCH_MS      = 2000;
    localparam longint MODE_DISCH_MS    = 100;
    localparam logic [31:0] ASSERT_CYCLES     = 32'(ASSERT_MS * CLK_KHZ);
    localparam logic [31:0] RELEASE_CYCLES    = 32'(RELEASE_MS * CLK_KHZ);
    localparam logic [31:0] PW_IDLE_CYCLES    = 32'(PW_IDLE_MS * CLK_KHZ);
    localparam logic [31:0] PW_DISCH_CYCLES   = 32'(PW_DISCH_MS * CLK_KHZ);
    localparam logic [31:0] MODE_DISCH_CYCLES = 32'(MODE_DISCH_MS * CLK_KHZ);

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] STATE_OFS      = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h0C;
    // Control fields and reset value.
    localparam int CTRL_HID_HOLD_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // State fields.
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_BUSY_BIT  = 3;
    localparam int ST_LOAD_BIT  = 4;
    localparam int ST_PW_LSB    = 5;
    localparam int ST_PINS_LSB  = 7;
    // Interrupt event bits.
    localparam int IRQ_W        = 4;
    localparam int EV_MODE_BIT  = 0;
    localparam int EV_LOAD_BIT  = 1;
    localparam int EV_FREE_BIT  = 2;
    localparam int EV_DONE_BIT  = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    typedef enum logic [2:0] {
        mode_discharge, dedicated_auto_mode, standard_port_first, dedicated_shorted_mode,
        divider_one_amp_mode, standard_port_second, charging_downstream
    } mode_e;
    typedef enum logic [1:0] {det_none, det_ordinary, det_power_wake, det_downstream} detect_e;
    typedef enum logic [1:0] {pw_active, pw_idle, pw_discharge} pw_e;

    typedef struct packed {
        mode_e   mode;
        logic    limit_high;
        logic    data_on;
        detect_e detect;
    } mode_cfg_s;
    localparam mode_cfg_s CFG_RESET = '{mode: mode_discharge, limit_high: 1'b0, data_on: 1'b0, detect: det_none};

    // Pins sampled from outside the clock domain.
    typedef struct packed {
        logic mode_select_a;
        logic mode_select_b;
        logic mode_select_c;
        logic limit_select;
        logic above_upper;
        logic below_lower;
        logic below_wake_floor;
        logic above_wake_ceiling;
        logic primary_detect;
        logic hid_present;
    } pins_s;
    localparam int PINS_W = $bits(pins_s);
endpackage
`default_nettype wire

// ==== dv/ec_pin_model.sv ====
// Controller model that drives the four mode select pins.
`default_nettype none
module ec_pin_model (
    // Clock and requested pattern
    input  wire logic       pclk,
    input  wire logic [3:0] pattern,
    // Mode select pins
    output var logic        mode_select_a,
    output var logic        mode_select_b,
    output var logic        mode_select_c,
    output var logic        limit_select
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {mode_select_a, mode_select_b, mode_select_c, limit_select} = 4'h0;
    // Any pattern is legal, so the model applies whatever it is told, just after an edge.
    always @(posedge pclk) begin
        {mode_select_a, mode_select_b, mode_select_c, limit_select} <= pattern;
    end
endmodule
`default_nettype wire

// ==== dv/tb_charge_mode_pin_decoder.sv ====
// Testbench of the charging-port mode decoder.
`default_nettype none
module tb_charge_mode_pin_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, irq, port_discharge, data_connect, limit_high_sel, limit_wake_sel, load_present_n;
    logic        load_above_upper = 0, load_below_lower = 0, load_below_wake_floor = 0, load_above_wake_ceiling = 0;
    logic        primary_detect = 0, hid_present = 0, mode_select_a, mode_select_b, mode_select_c, limit_select;
    logic [3:0]  pattern = 4'h0;
    logic [4:0]  exp_tab [16] = '{5'h11, 5'h11, 5'h05, 5'h04, 5'h09, 5'h0D, 5'h05, 5'h05,
                                 5'h01, 5'h05, 5'h01, 5'h05, 5'h09, 5'h0D, 5'h09, 5'h0D};
    int          fail_count = 0, tests_run = 0;
    charge_mode_pin_decoder #(.ASSERT_CYCLES(8), .RELEASE_CYCLES(8), .PW_IDLE_CYCLES(8), .PW_DISCH_CYCLES(8),
        .MODE_DISCH_CYCLES(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mode_select_a, .mode_select_b, .mode_select_c, .limit_select, .load_above_upper,
        .load_below_lower, .load_below_wake_floor, .load_above_wake_ceiling, .primary_detect, .hid_present,
        .port_discharge, .data_connect, .limit_high_sel, .limit_wake_sel, .load_present_n, .irq);
    ec_pin_model u_ec (.pclk, .pattern, .mode_select_a, .mode_select_b, .mode_select_c, .limit_select);
    initial begin
        forever #2 pclk = ~pclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is sampled high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        cyc(20000);
        fail_count++;
        results();
    end
    initial begin
        cyc(8);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 8'h0C, 32'h0000_000F);
        for (int p = 0; p < 16; p++) begin
            pattern <= 4'(p);
            cyc(40);
            chk({port_discharge, data_connect, limit_high_sel, limit_wake_sel, load_present_n}, exp_tab[p]);
        end
        chk(irq, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk(q[0], 1'b1);
        apb(1'b1, 8'h08, 32'h0000_000F);
        apb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0001_E006);
        apb(1'b1, 8'h0C, 32'h0);
        chk(irq, 1'b0);
        apb(1'b0, 8'h40, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0);
        $display("Mode table and registers done");
        for (int k = 0; k < 2; k++) begin
            pattern <= 4'(14 + k);
            repeat (20) begin
                @(posedge pclk);
                chk(port_discharge, 1'b0);
            end
        end
        primary_detect <= 1'b1;
        cyc(10);
        chk(load_present_n, 1'b0);
        primary_detect <= 1'b0;
        pattern <= 4'h7;
        cyc(40);
        load_above_upper <= 1'b1;
        cyc(4);
        chk(load_present_n, 1'b1);
        cyc(20);
        chk(load_present_n, 1'b0);
        load_above_upper <= 1'b0;
        load_below_lower <= 1'b1;
        cyc(30);
        chk(load_present_n, 1'b1);
        load_below_lower <= 1'b0;
        pattern <= 4'h3;
        cyc(40);
        load_below_wake_floor <= 1'b1;
        cyc(30);
        chk({load_present_n, limit_wake_sel}, 2'b11);
        load_below_wake_floor <= 1'b0;
        load_above_wake_ceiling <= 1'b1;
        cyc(8);
        chk({load_present_n, port_discharge}, 2'b01);
        load_above_wake_ceiling <= 1'b0;
        cyc(30);
        chk({load_present_n, port_discharge, limit_high_sel}, 3'b001);
        $display("Load detection done");
        pattern <= 4'hE;
        cyc(40);
        hid_present <= 1'b1;
        cyc(10);
        pattern <= 4'h3;
        cyc(40);
        chk(data_connect, 1'b1);
        hid_present <= 1'b0;
        cyc(40);
        chk({data_connect, irq}, 2'b00);
        $display("Hold test done");
        results();
    end
endmodule
`default_nettype wire
